//--- hdl/idl_datapath.sv
// execution datapath for increment/decrement, skip-on-zero and literal ops
// assumes the decoder presents one instruction per instruction_cycle and that
// the register file answers i_file_rdata combinationally for i_instr.file_addr
// and that a write-back lands in the file one edge after it is taken
//
// Overview of operation
// - decrement file, route by dest, update zero
// - increment file, route by dest, update zero
// - decrement-skip routes result, flags untouched
// - decrement-skip zero result inserts no_operation cycle
// - increment-skip routes sum, flags untouched
// - increment-skip zero result inserts no_operation cycle
// - OR literal into accumulator, update zero
// - load literal into accumulator, flags untouched
module idl_datapath (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_arst_n,
  input  wire idl_pkg::idl_instr_s      i_instr,
  input  wire logic [idl_pkg::DATA_W-1:0] i_file_rdata,
  output idl_pkg::idl_file_wr_s         o_file_wr,
  output logic [idl_pkg::DATA_W-1:0]    o_accumulator,
  output logic                          o_zero_flag,
  output logic                          o_discard_next,
  output logic                          o_nop_cycle
);
  import idl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state, accumulator, flag and write-back register declarations

  idl_state_e        state_q;
  idl_state_e        state_d;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  logic              zf_q;
  logic              zf_d;
  idl_file_wr_s      wr_q;
  idl_file_wr_s      wr_d;

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode

  // an instruction arriving during the no_operation cycle is the discarded one
  wire         in_nop    = (state_q == IDL_ST_NOP);
  wire         exec_ok   = i_instr.valid && !in_nop;
  wire         is_dec    = exec_ok && (i_instr.op == IDL_OP_DECREMENT_FILE);
  wire         is_inc    = exec_ok && (i_instr.op == IDL_OP_INCREMENT_FILE);
  wire         is_decsz  = exec_ok && (i_instr.op == IDL_OP_DECREMENT_SKIP_ZERO);
  wire         is_incsz  = exec_ok && (i_instr.op == IDL_OP_INCREMENT_SKIP_ZERO);
  wire         is_orl    = exec_ok && (i_instr.op == IDL_OP_OR_LITERAL_ACCUMULATOR);
  wire         is_movl   = exec_ok && (i_instr.op == IDL_OP_LOAD_LITERAL_ACCUMULATOR);
  wire         file_op   = is_dec || is_inc || is_decsz || is_incsz;
  wire         down_op   = is_dec || is_decsz;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic and routing

  // ripple chains drop the carry out of bit 7, so FF+1 gives 00 and 00-1
  // gives FF; a short chain was kept over an adder as the byte is narrow
  logic [DATA_W-1:0] carry;
  logic [DATA_W-1:0] borrow;
  logic [DATA_W-1:0] file_plus;
  logic [DATA_W-1:0] file_minus;
  logic [DATA_W-1:0] file_res;
  logic [DATA_W-1:0] or_res;
  logic [DATA_W-1:0] res_any;
  logic [DATA_W-1:0] or_any;

  assign carry[0]  = 1'b1;
  assign borrow[0] = 1'b1;

  // one slice per bit: increment, decrement, literal or and running zero test
  for (genvar b = 0; b < DATA_W; b++) begin : g_bit
    assign file_plus[b]  = i_file_rdata[b] ^ carry[b];
    assign file_minus[b] = i_file_rdata[b] ^ borrow[b];
    assign file_res[b]   = down_op ? file_minus[b] : file_plus[b];
    assign or_res[b]     = acc_q[b] | i_instr.literal[b];
    if (b == 0) begin : g_first
      assign res_any[b] = file_res[b];
      assign or_any[b]  = or_res[b];
    end else begin : g_next
      assign res_any[b] = res_any[b-1] | file_res[b];
      assign or_any[b]  = or_any[b-1] | or_res[b];
    end
    if (b < DATA_W-1) begin : g_chain
      assign carry[b+1]  = i_file_rdata[b] & carry[b];
      assign borrow[b+1] = ~i_file_rdata[b] & borrow[b];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero detect and routing

  // the skip and the flag both read the finished byte, so they cannot disagree
  wire              res_zero  = ~res_any[DATA_W-1];
  wire              or_zero   = ~or_any[DATA_W-1];
  wire              to_acc    = file_op && (i_instr.dest_select == DEST_ACC);
  wire              to_file   = file_op && (i_instr.dest_select == DEST_FILE);
  wire              skip_op   = is_decsz || is_incsz;
  wire              skip_zero = skip_op && res_zero;
  wire              zf_update = is_dec || is_inc || is_orl;
  wire              zf_new    = is_orl ? or_zero : res_zero;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  // op is one-hot, so at most one branch below can be live in a cycle

  always_comb begin
    acc_d = acc_q;
    if (to_acc) begin
      acc_d = file_res;
    end else if (is_orl) begin
      acc_d = or_res;
    end else if (is_movl) begin
      acc_d = i_instr.literal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero flag

  // the flag holds unless an op that affects it was taken
  always_comb begin
    zf_d = zf_q;
    if (zf_update) begin
      zf_d = zf_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-back

  // the bus rests at zero between writes so a stray address never shows
  always_comb begin
    wr_d = '0;
    if (to_file) begin
      wr_d.we   = 1'b1;
      wr_d.addr = i_instr.file_addr;
      wr_d.data = file_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip sequencing

  // the instruction behind a taken skip still arrives from fetch; this
  // block turns it into the no_operation cycle instead of stalling fetch,
  // so a skip costs exactly one extra instruction_cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDL_ST_EXEC: begin
        if (skip_zero) begin
          state_d = IDL_ST_NOP;
        end
      end
      IDL_ST_NOP: begin
        state_d = IDL_ST_EXEC;
      end
      default: begin
        state_d = IDL_ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // one short process per register keeps each reset value beside its use
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= IDL_ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_q <= ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zf_q <= ZF_RESET;
    end else begin
      zf_q <= zf_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_file_wr      = wr_q;
  assign o_accumulator  = acc_q;
  assign o_zero_flag    = zf_q;
  // both strobes follow the state register and so rise and fall together;
  // fetch uses the first to squash, status logic the second
  assign o_discard_next = in_nop;
  assign o_nop_cycle    = in_nop;

endmodule

//--- shared/idl_pkg.sv
// package for the increment/decrement/literal execution datapath
// assumes one clock domain, decoder presents one operation per instruction cycle
package idl_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int OP_W    = 6;

  localparam logic [ADDR_W-1:0] ADDR_MAX   = 7'h7F;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic              ZF_RESET   = 1'b0;
  localparam logic              DEST_ACC   = 1'b0;
  localparam logic              DEST_FILE  = 1'b1;

  // one-hot operation codes from the decoder
  typedef enum logic [OP_W-1:0] {
    IDL_OP_NONE                     = 6'h00,
    IDL_OP_DECREMENT_FILE           = 6'h01,
    IDL_OP_INCREMENT_FILE           = 6'h02,
    IDL_OP_DECREMENT_SKIP_ZERO      = 6'h04,
    IDL_OP_INCREMENT_SKIP_ZERO      = 6'h08,
    IDL_OP_OR_LITERAL_ACCUMULATOR   = 6'h10,
    IDL_OP_LOAD_LITERAL_ACCUMULATOR = 6'h20
  } idl_op_e;

  // pipeline state: normal execute or the inserted no_operation cycle
  typedef enum logic [1:0] {
    IDL_ST_EXEC    = 2'b01,
    IDL_ST_NOP     = 2'b10
  } idl_state_e;

  typedef struct packed {
    logic              valid;
    idl_op_e           op;
    logic [ADDR_W-1:0] file_addr;
    logic              dest_select;
    logic [DATA_W-1:0] literal;
  } idl_instr_s;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } idl_file_wr_s;

endpackage

//--- tb/idl_datapath_properties.sv
// port checks for idl_datapath
// bound to each instance, sees its ports only
module idl_datapath_properties import idl_pkg::*; (
  input wire logic         i_sys_clk,
  input wire logic         i_arst_n,
  input wire idl_instr_s   i_instr,
  input wire logic [7:0]   i_file_rdata,
  input wire idl_file_wr_s o_file_wr,
  input wire logic [7:0]   o_accumulator,
  input wire logic         o_zero_flag,
  input wire logic         o_discard_next,
  input wire logic         o_nop_cycle);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  wire [5:0] p = i_instr.valid && !o_discard_next ? i_instr.op : 6'h00;
  wire [7:0] r = i_file_rdata;
  wire [7:0] a = o_accumulator;
  wire       z = o_zero_flag;
  AST_DEC: assert property (p[0] && !i_instr.dest_select |=>
    a == $past(r) - 8'h01 && z == ($past(r) == 8'h01)) else $error("dec");
  AST_INC: assert property (p[1] && i_instr.dest_select |=>
    o_file_wr.we && o_file_wr.data == $past(r) + 8'h01) else $error("inc");
  AST_ZF: assert property (p[2] | p[3] |=> $stable(z))
    else $error("zf");
  AST_SKD: assert property (p[2] && r == 8'h01 |=> o_discard_next)
    else $error("skd");
  AST_SKI: assert property (p[3] && r != 8'hFF |=> !o_discard_next)
    else $error("ski");
  AST_OR: assert property (p[4] |=> a == ($past(a) | $past(i_instr.literal))
    && z == (a == 8'h00)) else $error("or");
  AST_LD: assert property (p[5] |=> a == $past(i_instr.literal) && $stable(z))
    else $error("ld");
  AST_NOP: assert property (o_discard_next |-> o_nop_cycle ##1
    (!o_discard_next && !o_file_wr.we && $stable(a))) else $error("nop");
  cover property (p[2] && r == 8'h01);
  cover property (p[3] && r == 8'hFF);
  cover property (o_discard_next && i_instr.valid);
endmodule
bind idl_datapath idl_datapath_properties u_prop (
  .i_sys_clk      (i_sys_clk),
  .i_arst_n       (i_arst_n),
  .i_instr        (i_instr),
  .i_file_rdata   (i_file_rdata),
  .o_file_wr      (o_file_wr),
  .o_accumulator  (o_accumulator),
  .o_zero_flag    (o_zero_flag),
  .o_discard_next (o_discard_next),
  .o_nop_cycle    (o_nop_cycle)
);

//--- tb/idl_datapath_tb.sv
// random instruction stream bench for idl_datapath
// file model preset to byte 2a-1 at address a
module idl_datapath_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import idl_pkg::*;
  logic         i_sys_clk = 1'b0, i_arst_n = 1'b0, zf = 1'b0, sk = 1'b0, d, z, n;
  logic [7:0]   ac = 8'h00, a, rd, sh [128];
  logic [26:0]  q [$], e, o;
  idl_instr_s   i_instr = '0;
  idl_file_wr_s w;
  int           fails, n_checks, seed = 32'h0687440C;
  always #25 i_sys_clk = ~i_sys_clk;
  idl_datapath DUT (.i_sys_clk, .i_arst_n, .i_instr, .i_file_rdata(rd), .o_file_wr(w),
    .o_accumulator(a), .o_zero_flag(z), .o_discard_next(d), .o_nop_cycle(n));
  idl_regfile_model u_rf (.i_sys_clk, .i_wr(w), .i_addr(i_instr.file_addr), .o_rdata(rd));
  always @(posedge i_sys_clk) if (q.size() > 0) begin
    #10 o = {a, z, w.we ? w : 16'h0000, d, n};
    e = q.pop_front();
    n_checks++;
    if (o !== e) begin
      fails++;
      $display("ERROR result expected %h seen %h", e, o);
    end
  end
  task automatic step();
    logic [31:0] s = $random(seed);
    logic [5:0]  op = 6'h01 << s[2:0];
    logic [7:0]  r, x;
    logic        t, we;
    @(posedge i_sys_clk) #1;
    i_instr = '{|s[31:30], idl_op_e'(op), s[3] ? s[10:4] : 7'(s[5:4]), s[11], s[19:12]};
    r = sh[i_instr.file_addr];
    t = i_instr.valid && !sk && op != 6'h00;
    x = op[0] | op[2] ? r - 8'h01 : op[1] | op[3] ? r + 8'h01 : op[4] ? ac | s[19:12] : s[19:12];
    we = t && op < 6'h10 && i_instr.dest_select;
    sk = t && (op[2] | op[3]) && x == 8'h00;
    if (we) sh[i_instr.file_addr] = x;
    else if (t) ac = x;
    if (t && (op[0] | op[1] | op[4])) zf = x == 8'h00;
    @(negedge i_sys_clk) q.push_back({ac, zf, we ? {1'b1, i_instr.file_addr, x} : 16'h0000, sk, sk});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 128; i++) sh[i] = 8'(2 * i - 1);
    repeat (20) @(posedge i_sys_clk);
    #1 i_arst_n = 1'b1;
    repeat (3000) step();
    @(posedge i_sys_clk) #20 if (q.size() > 0) fails++;
    $display("random stream done");
    summarize();
  end
endmodule

//--- tb/idl_regfile_model.sv
// file model, reads answer at once
// assumes preset byte 2a-1 at address a
module idl_regfile_model import idl_pkg::*; (
  input  wire logic         i_sys_clk,
  input  wire idl_file_wr_s i_wr,
  input  wire logic [6:0]   i_addr,
  output logic [7:0]        o_rdata);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [128];
  // write-through, since write-back lands a cycle after the read
  assign o_rdata = i_wr.we && i_wr.addr == i_addr ? i_wr.data : m[i_addr];
  always @(posedge i_sys_clk) if (i_wr.we) m[i_wr.addr] <= i_wr.data;
  initial for (int i = 0; i < 128; i++) m[i] = 8'(2 * i - 1);
endmodule
